// ---- src/nis_pkg.sv ----
// Constants for the next instruction sequencer.
// Assumes a 48-bit storage word holding two 24-bit instructions, f6 b3 m15.
//
// Contract
// - Resume a storage wait only on begin pulse while wait flag is set.
// - Full fetch loads the whole 48-bit storage word into program control reg.
// - Half fetch moves lower 24 bits up, no storage reference.
// - Full fetch entered from full exit, jump exit or initial start.
// - Later segment entered from half exit or full fetch resume.
// - Full fetch: initiate, wait, resume, set flag, clear reg, load word.
// - Half fetch: clear flag, clear upper half, copy lower to upper.
// - Initial start fetches once after master clear; later starts execute directly.
// - Sweep mode suppresses instruction initiates and re-enters fetch by flag.
// - Step key sets first latch; fetch moves it into main stop latch.
// - Breakpoint compare on program address blocks the final fetch step.
// - Program stops act in instruction sequences; fault stops just halt.
// - Restart from stop clears the main stop latch.
// - Designator 1-6: index via intermediate to adder input; copy control reg.
// - Fetch end: clear exchange, partial add, Q forward, complement X, R forward.
// - Interrupt entry saves address at 00007, saves flag, sets request block.
// - While request block is set, no further interrupt is acknowledged.
// - Jump fetch of location 00007 sets routine finished flag.
// - Next jump fetch clears both flags; resumes upper or half path by saved flag.
// - Designator 7 is indirect except codes 22, 23, 74, 75, 76.
// - Indirect read replaces designator and address with lower 18 bits.
// - Indirect step repeats while the new designator is 7.
// - Indirect applies also to codes using the address as operand.
// - Full fetch sets pair position flag; half fetch clears it.
// - Jump exit enters full fetch without advancing the program address.
package nis_pkg;
  localparam int WORD_W   = 48;
  localparam int INSTR_W  = 24;
  localparam int ADDR_W   = 15;
  localparam int BM_W     = 18;
  localparam int F_LSB    = 18;
  localparam int B_LSB    = 15;
  localparam logic [2:0] B_INDIRECT = 3'h7;
  localparam logic [2:0] B_NONE     = 3'h0;
  localparam logic [5:0] F_DIR0 = 6'h12;  // octal 22
  localparam logic [5:0] F_DIR1 = 6'h13;  // octal 23
  localparam logic [5:0] F_DIR2 = 6'h3C;  // octal 74
  localparam logic [5:0] F_DIR3 = 6'h3D;  // octal 75
  localparam logic [5:0] F_DIR4 = 6'h3E;  // octal 76
  localparam logic [14:0] IRQ_ADDR = 15'h0007;
  localparam logic [14:0] P_RESET  = 15'h0000;

  typedef enum logic [3:0] {
    NIS_IDLE, NIS_FULL_WAIT, NIS_FULL_LOAD, NIS_HALF, NIS_INDEX,
    NIS_CHECK, NIS_IND_WAIT, NIS_IND_LOAD, NIS_FINAL, NIS_HOLD
  } nis_state_t;
endpackage : nis_pkg

// ---- src/nis_sequencer.sv ----
// Next instruction fetch sequencer.
// Assumes storage answers with a begin pulse, then a resume with data valid.
`timescale 1ns/1ps
module nis_sequencer (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // Console
  input  wire logic        master_clear,
  input  wire logic        start_key,
  input  wire logic        step_key,
  input  wire logic        sweep_mode,
  input  wire logic [14:0] breakpoint_addr,
  input  wire logic        breakpoint_en,
  // Exits from instruction sequences
  input  wire logic        full_exit,
  input  wire logic        half_exit,
  input  wire logic        jump_exit,
  input  wire logic [14:0] jump_target,
  input  wire logic        program_stop,
  input  wire logic        fault_stop,
  // Interrupt entry from the acknowledge sequence
  input  wire logic        irq_enter,
  // Storage sequence
  input  wire logic        stor_begin,
  input  wire logic        stor_resume,
  input  wire logic [47:0] stor_data,
  output logic             stor_init,
  output logic [14:0]      stor_addr,
  output logic [14:0]      stor_wdata,
  output logic             stor_write,
  // Index path
  output logic [2:0]       index_sel,
  output logic             index_to_adder,
  // Handoff to instruction sequences
  output logic             instr_init,
  output logic [23:0]      instr_word,
  output logic             prelim_cmds,
  output logic             copy_ctrl_fwd,
  // Status
  output logic [47:0]      program_control_reg,
  output logic [14:0]      program_addr,
  output logic             pair_position_flag,
  output logic             main_stop_latch,
  output logic             second_request_block,
  output logic             saved_pair_position,
  output logic             routine_finished_flag,
  output logic             irq_ack_allowed,
  output logic             running
);

  nis_pkg::nis_state_t state;
  logic       initial_start_done;
  logic       first_stop_latch;
  logic       wait_storage;
  logic       began;
  logic       via_jump;
  logic       skip_fetch;
  logic [5:0] f_code;
  logic [2:0] b_desig;
  logic       is_direct_code;
  logic       bp_hit;
  logic       stop_now;
  logic       sweep_refetch;

  assign f_code  = program_control_reg[47:42];
  assign b_desig = program_control_reg[41:39];
  assign is_direct_code = (f_code == nis_pkg::F_DIR0) || (f_code == nis_pkg::F_DIR1) ||
                          (f_code == nis_pkg::F_DIR2) || (f_code == nis_pkg::F_DIR3) ||
                          (f_code == nis_pkg::F_DIR4);
  assign bp_hit   = breakpoint_en && (program_addr == breakpoint_addr);
  assign stop_now = first_stop_latch || bp_hit;
  // Sweep refetches by itself; storage path only when no lower word waits
  assign sweep_refetch = (state == nis_pkg::NIS_FINAL) && sweep_mode && !pair_position_flag &&
                         !master_clear;

  // Main fetch chain
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= nis_pkg::NIS_IDLE;
    end else if (master_clear) begin
      state <= nis_pkg::NIS_IDLE;
    end else begin
      unique case (state)
        nis_pkg::NIS_IDLE: begin
          if (full_exit || jump_exit || (start_key && !initial_start_done)) begin
            state <= nis_pkg::NIS_FULL_WAIT;
          end else if (half_exit) begin
            state <= nis_pkg::NIS_HALF;
          end
        end
        nis_pkg::NIS_FULL_WAIT: begin
          if (stor_resume && began) begin
            state <= nis_pkg::NIS_FULL_LOAD;
          end
        end
        nis_pkg::NIS_FULL_LOAD: begin
          state <= skip_fetch ? nis_pkg::NIS_HALF : nis_pkg::NIS_INDEX;
        end
        nis_pkg::NIS_HALF:  state <= nis_pkg::NIS_INDEX;
        nis_pkg::NIS_INDEX: state <= nis_pkg::NIS_CHECK;
        nis_pkg::NIS_CHECK: begin
          if (b_desig == nis_pkg::B_INDIRECT && !is_direct_code) begin
            state <= nis_pkg::NIS_IND_WAIT;
          end else if (stop_now) begin
            state <= nis_pkg::NIS_HOLD;
          end else begin
            state <= nis_pkg::NIS_FINAL;
          end
        end
        nis_pkg::NIS_IND_WAIT: begin
          if (stor_resume && began) begin
            state <= nis_pkg::NIS_IND_LOAD;
          end
        end
        nis_pkg::NIS_IND_LOAD: state <= nis_pkg::NIS_CHECK;
        nis_pkg::NIS_FINAL: begin
          if (sweep_mode) begin
            state <= pair_position_flag ? nis_pkg::NIS_HALF : nis_pkg::NIS_FULL_WAIT;
          end else begin
            state <= nis_pkg::NIS_IDLE;
          end
        end
        nis_pkg::NIS_HOLD: begin
          if (start_key) begin
            state <= nis_pkg::NIS_FINAL;
          end
        end
        default: state <= nis_pkg::NIS_IDLE;
      endcase
    end
  end

  // Storage handshake: begin recorded only while waiting
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wait_storage <= 1'b0;
      began        <= 1'b0;
      stor_init    <= 1'b0;
      stor_addr    <= nis_pkg::P_RESET;
    end else begin
      stor_init <= 1'b0;
      if ((state == nis_pkg::NIS_IDLE &&
           (full_exit || jump_exit || (start_key && !initial_start_done))) || sweep_refetch) begin
        stor_init    <= 1'b1;
        wait_storage <= 1'b1;
        began        <= 1'b0;
        stor_addr    <= (jump_exit && !sweep_refetch) ? jump_target :
                        ((full_exit || sweep_refetch) ? 15'(program_addr + 15'h0001) :
                         program_addr);
      end else if (state == nis_pkg::NIS_CHECK && b_desig == nis_pkg::B_INDIRECT &&
                   !is_direct_code) begin
        stor_init    <= 1'b1;
        wait_storage <= 1'b1;
        began        <= 1'b0;
        stor_addr    <= program_control_reg[38:24];
      end else if (stor_resume && began) begin
        wait_storage <= 1'b0;
        began        <= 1'b0;
      end else if (stor_begin && wait_storage) begin
        began <= 1'b1;
      end
      // Return address goes to the fixed save location
      if (irq_enter && !second_request_block) begin
        stor_addr <= nis_pkg::IRQ_ADDR;
      end
    end
  end

  // Program address
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      program_addr <= nis_pkg::P_RESET;
    end else if (master_clear) begin
      program_addr <= nis_pkg::P_RESET;
    end else if (state == nis_pkg::NIS_IDLE && jump_exit) begin
      program_addr <= jump_target;
    end else if ((state == nis_pkg::NIS_IDLE && full_exit) || sweep_refetch) begin
      program_addr <= 15'(program_addr + 15'h0001);
    end
  end

  // Program control register
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      program_control_reg <= '0;
    end else if (state == nis_pkg::NIS_FULL_LOAD) begin
      program_control_reg <= stor_data;
    end else if (state == nis_pkg::NIS_HALF) begin
      program_control_reg[47:24] <= program_control_reg[23:0];
    end else if (state == nis_pkg::NIS_IND_LOAD) begin
      program_control_reg[41:24] <= stor_data[17:0];
    end
  end

  // Pair position flag
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pair_position_flag <= 1'b0;
    end else if (state == nis_pkg::NIS_FULL_LOAD) begin
      pair_position_flag <= 1'b1;
    end else if (state == nis_pkg::NIS_HALF) begin
      pair_position_flag <= 1'b0;
    end
  end

  // Start and stop latches
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      initial_start_done <= 1'b0;
      first_stop_latch   <= 1'b0;
      main_stop_latch    <= 1'b0;
      running            <= 1'b0;
    end else if (master_clear) begin
      initial_start_done <= 1'b0;
      first_stop_latch   <= 1'b0;
      main_stop_latch    <= 1'b0;
      running            <= 1'b0;
    end else begin
      if (start_key) begin
        initial_start_done <= 1'b1;
        running            <= 1'b1;
      end else if (fault_stop) begin
        running <= 1'b0;
      end
      if (step_key) begin
        first_stop_latch <= 1'b1;
      end else if (state == nis_pkg::NIS_CHECK && stop_now) begin
        first_stop_latch <= 1'b0;
      end
      if (state == nis_pkg::NIS_CHECK && stop_now) begin
        main_stop_latch <= 1'b1;
      end else if (program_stop) begin
        main_stop_latch <= 1'b1;
      end else if (start_key) begin
        main_stop_latch <= 1'b0;
      end
    end
  end

  // Handoff, index setup and common preliminary commands
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      instr_init     <= 1'b0;
      instr_word     <= '0;
      prelim_cmds    <= 1'b0;
      index_sel      <= nis_pkg::B_NONE;
      index_to_adder <= 1'b0;
      copy_ctrl_fwd  <= 1'b0;
    end else begin
      index_to_adder <= 1'b0;
      copy_ctrl_fwd  <= 1'b0;
      prelim_cmds    <= 1'b0;
      instr_init     <= 1'b0;
      if (state == nis_pkg::NIS_INDEX) begin
        copy_ctrl_fwd <= 1'b1;
        if (b_desig != nis_pkg::B_NONE && b_desig != nis_pkg::B_INDIRECT) begin
          index_sel      <= b_desig;
          index_to_adder <= 1'b1;
        end
      end
      if (state == nis_pkg::NIS_FINAL) begin
        prelim_cmds <= 1'b1;
        instr_word  <= program_control_reg[47:24];
        instr_init  <= !sweep_mode;
      end
    end
  end

  // Interrupt bookkeeping
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      second_request_block  <= 1'b0;
      saved_pair_position   <= 1'b0;
      routine_finished_flag <= 1'b0;
      skip_fetch            <= 1'b0;
      via_jump              <= 1'b0;
      stor_write            <= 1'b0;
      stor_wdata            <= '0;
      irq_ack_allowed       <= 1'b0;
    end else begin
      stor_write      <= 1'b0;
      irq_ack_allowed <= !second_request_block && !irq_enter;
      if (state == nis_pkg::NIS_IDLE && (full_exit || jump_exit)) begin
        via_jump <= jump_exit;
      end else if (sweep_refetch) begin
        via_jump <= 1'b0;
      end
      if (irq_enter && !second_request_block) begin
        stor_write           <= 1'b1;
        stor_wdata           <= program_addr;
        saved_pair_position  <= pair_position_flag;
        second_request_block <= 1'b1;
      end else if (state == nis_pkg::NIS_FULL_WAIT && stor_resume && began && via_jump) begin
        if (routine_finished_flag) begin
          second_request_block  <= 1'b0;
          routine_finished_flag <= 1'b0;
          skip_fetch            <= !saved_pair_position;
        end else if (program_addr == nis_pkg::IRQ_ADDR) begin
          routine_finished_flag <= 1'b1;
        end
      end else if (state == nis_pkg::NIS_FULL_LOAD) begin
        skip_fetch <= 1'b0;
      end
    end
  end

  // Sequence ordering checks
  resume_needs_begin_a: assert property (@(posedge clk) disable iff (sys_rst)
    (state == nis_pkg::NIS_FULL_WAIT && stor_resume && !began && !master_clear)
      |=> state == nis_pkg::NIS_FULL_WAIT)
    else $error("resume without begin advanced fetch");
  full_load_word_a: assert property (@(posedge clk) disable iff (sys_rst)
    state == nis_pkg::NIS_FULL_LOAD |=> program_control_reg == $past(stor_data))
    else $error("full fetch did not load word");
  half_move_a: assert property (@(posedge clk) disable iff (sys_rst)
    state == nis_pkg::NIS_HALF |=>
      program_control_reg[47:24] == $past(program_control_reg[23:0]) && !pair_position_flag)
    else $error("half fetch move wrong");
  full_entry_a: assert property (@(posedge clk) disable iff (sys_rst)
    (state == nis_pkg::NIS_IDLE && !master_clear && (full_exit || jump_exit)) |=>
      stor_init && state == nis_pkg::NIS_FULL_WAIT)
    else $error("full fetch entry did not initiate storage");
  flag_set_a: assert property (@(posedge clk) disable iff (sys_rst)
    state == nis_pkg::NIS_FULL_LOAD |=> pair_position_flag)
    else $error("pair flag not set by full fetch");
  indirect_sub_a: assert property (@(posedge clk) disable iff (sys_rst)
    state == nis_pkg::NIS_IND_LOAD |=>
      program_control_reg[41:24] == $past(stor_data[17:0]) && state == nis_pkg::NIS_CHECK)
    else $error("indirect substitution wrong");
  direct_codes_a: assert property (@(posedge clk) disable iff (sys_rst)
    (state == nis_pkg::NIS_CHECK && is_direct_code && !master_clear) |=>
      state != nis_pkg::NIS_IND_WAIT)
    else $error("direct code went indirect");
  stop_blocks_a: assert property (@(posedge clk) disable iff (sys_rst)
    (state == nis_pkg::NIS_CHECK && stop_now && b_desig != nis_pkg::B_INDIRECT &&
     !master_clear) |=> state == nis_pkg::NIS_HOLD ##1 !instr_init)
    else $error("stop did not block final step");
  sweep_none_a: assert property (@(posedge clk) disable iff (sys_rst)
    sweep_mode && state == nis_pkg::NIS_FINAL |=> !instr_init && prelim_cmds)
    else $error("sweep mode initiated instruction");
  lockout_ack_a: assert property (@(posedge clk) disable iff (sys_rst)
    second_request_block |=> !irq_ack_allowed)
    else $error("ack allowed under lockout");
  irq_save_a: assert property (@(posedge clk) disable iff (sys_rst)
    (irq_enter && !second_request_block) |=>
      second_request_block && saved_pair_position == $past(pair_position_flag))
    else $error("interrupt entry not recorded");
  half_entry_a: assert property (@(posedge clk) disable iff (sys_rst)
    (state == nis_pkg::NIS_IDLE && half_exit && !full_exit && !jump_exit && !start_key &&
     !master_clear) |=> state == nis_pkg::NIS_HALF)
    else $error("half exit did not enter half fetch");
  index_route_a: assert property (@(posedge clk) disable iff (sys_rst)
    (state == nis_pkg::NIS_INDEX && b_desig != nis_pkg::B_NONE &&
     b_desig != nis_pkg::B_INDIRECT) |=>
      index_to_adder && copy_ctrl_fwd && index_sel == $past(b_desig))
    else $error("index setup missing");
  prelim_end_a: assert property (@(posedge clk) disable iff (sys_rst)
    state == nis_pkg::NIS_FINAL |=> prelim_cmds)
    else $error("common commands missing at fetch end");
  restart_clear_a: assert property (@(posedge clk) disable iff (sys_rst)
    (state == nis_pkg::NIS_HOLD && start_key && !program_stop) |=> !main_stop_latch)
    else $error("restart left stop latch set");
  indirect_init_a: assert property (@(posedge clk) disable iff (sys_rst)
    (state == nis_pkg::NIS_CHECK && b_desig == nis_pkg::B_INDIRECT && !is_direct_code &&
     !master_clear) |=> stor_init && state == nis_pkg::NIS_IND_WAIT)
    else $error("indirect designator did not start a reference");
  sweep_refetch_a: assert property (@(posedge clk) disable iff (sys_rst)
    sweep_refetch |=> stor_init && state == nis_pkg::NIS_FULL_WAIT)
    else $error("sweep did not refetch");
  start_once_a: assert property (@(posedge clk) disable iff (sys_rst)
    (state == nis_pkg::NIS_IDLE && start_key && initial_start_done && !full_exit &&
     !jump_exit) |=> !stor_init)
    else $error("second start fetched from storage");
  routine_set_a: assert property (@(posedge clk) disable iff (sys_rst)
    (state == nis_pkg::NIS_FULL_WAIT && stor_resume && began && via_jump && !irq_enter &&
     !routine_finished_flag && program_addr == nis_pkg::IRQ_ADDR) |=> routine_finished_flag)
    else $error("return fetch did not mark routine finished");

endmodule : nis_sequencer

// ---- sim/nis_storage_model.sv ----
// Behavioural storage sequence that answers the fetch sequencer.
// Assumes one request at a time; contents are preloaded by the bench.
`timescale 1ns/1ps
module nis_storage_model (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // Requests from the sequencer
  input  wire logic        stor_init,
  input  wire logic [14:0] stor_addr,
  // Answers
  output logic             stor_begin,
  output logic             stor_resume,
  output logic [47:0]      stor_data
);
  logic [47:0] mem [0:15];
  logic        busy;
  logic        slow;
  logic [3:0]  addr_q;
  logic [3:0]  cnt;

  // Begin always leads resume; every other access is slow
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      busy        <= 1'b0;
      slow        <= 1'b0;
      addr_q      <= 4'h0;
      cnt         <= 4'h0;
      stor_begin  <= 1'b0;
      stor_resume <= 1'b0;
      stor_data   <= 48'h0;
    end else begin
      stor_begin  <= 1'b0;
      stor_resume <= 1'b0;
      if (stor_init) begin
        // Data stand until the next request, then turn stale on purpose
        stor_data <= ~stor_data;
        busy   <= 1'b1;
        cnt    <= 4'h0;
        addr_q <= stor_addr[3:0];
      end else if (busy) begin
        cnt <= cnt + 4'h1;
        if (cnt == 4'h1) stor_begin <= 1'b1;
        if (cnt == (slow ? 4'h7 : 4'h3)) begin
          stor_resume <= 1'b1;
          stor_data   <= mem[addr_q];
          busy        <= 1'b0;
          slow        <= ~slow;
        end
      end
    end
  end
endmodule : nis_storage_model

// ---- sim/testbench.sv ----
// Self-checking bench for the next instruction fetch sequencer.
// Assumes the storage model stands on the storage port; console is driven here.
`timescale 1ns/1ps
module testbench;
  logic        clk, sys_rst, master_clear, start_key, step_key, sweep_mode;
  logic        breakpoint_en, full_exit, half_exit, jump_exit, program_stop, fault_stop;
  logic        irq_enter, stor_begin, stor_resume, stor_init, stor_write, index_to_adder;
  logic        instr_init, prelim_cmds, copy_ctrl_fwd, pair_position_flag, main_stop_latch;
  logic        second_request_block, saved_pair_position, routine_finished_flag;
  logic        irq_ack_allowed, running, seen, pre;
  logic [14:0] breakpoint_addr, jump_target, stor_addr, stor_wdata, program_addr, p0, wr_addr;
  logic [47:0] stor_data, program_control_reg;
  logic [23:0] instr_word, word;
  logic [2:0]  index_sel, idx;
  logic [5:0]  codes [0:6];
  int          mismatches, n_tests, cycles, n_init, k0, n_copy;
  localparam logic [47:0] W = {6'h0C, 3'h0, 15'h0005, 6'h0D, 3'h3, 15'h0006};

  nis_sequencer nis_sequencer_inst (.clk(clk), .sys_rst(sys_rst), .master_clear(master_clear),
    .start_key(start_key), .step_key(step_key), .sweep_mode(sweep_mode),
    .breakpoint_addr(breakpoint_addr), .breakpoint_en(breakpoint_en), .full_exit(full_exit),
    .half_exit(half_exit), .jump_exit(jump_exit), .jump_target(jump_target),
    .program_stop(program_stop), .fault_stop(fault_stop), .irq_enter(irq_enter),
    .stor_begin(stor_begin), .stor_resume(stor_resume), .stor_data(stor_data),
    .stor_init(stor_init), .stor_addr(stor_addr), .stor_wdata(stor_wdata),
    .stor_write(stor_write), .index_sel(index_sel), .index_to_adder(index_to_adder),
    .instr_init(instr_init), .instr_word(instr_word), .prelim_cmds(prelim_cmds),
    .copy_ctrl_fwd(copy_ctrl_fwd), .program_control_reg(program_control_reg),
    .program_addr(program_addr), .pair_position_flag(pair_position_flag),
    .main_stop_latch(main_stop_latch), .second_request_block(second_request_block),
    .saved_pair_position(saved_pair_position), .routine_finished_flag(routine_finished_flag),
    .irq_ack_allowed(irq_ack_allowed), .running(running));
  nis_storage_model nis_storage_model_inst (.clk(clk), .sys_rst(sys_rst),
    .stor_init(stor_init), .stor_addr(stor_addr), .stor_begin(stor_begin),
    .stor_resume(stor_resume), .stor_data(stor_data));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (stor_init === 1'b1) n_init <= n_init + 1;
    if (copy_ctrl_fwd === 1'b1) n_copy <= n_copy + 1;
    if (index_to_adder === 1'b1) idx <= index_sel;
    if (stor_write === 1'b1) wr_addr <= stor_addr;
    if (cycles == 20000) begin
      mismatches++;
      print_verdict();
    end
  end

  task automatic check(input string nm, input logic [47:0] exp, input logic [47:0] got);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : check

  // 0 full, 1 half, 2 jump, 3 start, 4 step, 5 interrupt, 6 fault, 7 program stop
  task automatic go(input int k);
    @(posedge clk);
    case (k)
      0: full_exit <= 1'b1;
      1: half_exit <= 1'b1;
      2: jump_exit <= 1'b1;
      3: start_key <= 1'b1;
      4: step_key  <= 1'b1;
      5: irq_enter <= 1'b1;
      7: program_stop <= 1'b1;
      default: fault_stop <= 1'b1;
    endcase
    @(posedge clk);
    {full_exit, half_exit, jump_exit, start_key, step_key, irq_enter, fault_stop} <= 7'h00;
    program_stop <= 1'b0;
  endtask : go

  task automatic wait_instr();
    seen = 1'b0;
    repeat (80) begin
      @(posedge clk);
      #1;
      if (instr_init === 1'b1) begin
        seen = 1'b1;
        pre  = prelim_cmds;
        word = instr_word;
        break;
      end
    end
    repeat (3) @(posedge clk);
  endtask : wait_instr

  task automatic jump(input logic [14:0] t);
    jump_target <= t;
    go(2);
    wait_instr();
  endtask : jump

  task print_verdict();
    if (mismatches == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : print_verdict

  initial begin
    {master_clear, start_key, step_key, sweep_mode, breakpoint_en, full_exit} = 6'h00;
    {half_exit, jump_exit, program_stop, fault_stop, irq_enter} = 5'h00;
    breakpoint_addr = 15'h0000;
    jump_target = 15'h0000;
    {mismatches, n_tests, cycles, n_init, n_copy} = 0;
    idx = 3'h0;
    wr_addr = 15'h0000;
    for (int i = 0; i < 16; i++) nis_storage_model_inst.mem[i] = W;
    nis_storage_model_inst.mem[10] = {6'h0C, 3'h7, 15'h000B, 24'h000000};
    nis_storage_model_inst.mem[11] = {30'h0, 3'h7, 15'h000C};
    nis_storage_model_inst.mem[12] = {30'h0, 3'h0, 15'h00AB};
    codes = '{nis_pkg::F_DIR0, nis_pkg::F_DIR1, nis_pkg::F_DIR2, nis_pkg::F_DIR3,
              nis_pkg::F_DIR4, 6'h01, 6'h0C};
    sys_rst = 1'b1;
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    master_clear <= 1'b1;
    @(posedge clk);
    master_clear <= 1'b0;
    go(3);
    wait_instr();
    check("full word", W, program_control_reg);
    check("full flag", 1, pair_position_flag);
    check("full instr", W[47:24], word);
    check("prelim", 1, pre);
    check("copy fwd", 1, n_copy);
    k0 = n_init;
    go(1);
    wait_instr();
    check("half word", {W[23:0], W[23:0]}, program_control_reg);
    check("half flag", 0, pair_position_flag);
    check("half storage", k0, n_init);
    check("index sel", 3'h3, idx);
    p0 = program_addr;
    go(0);
    wait_instr();
    check("full advance", p0 + 15'h1, program_addr);
    breakpoint_addr <= 15'h0005;
    breakpoint_en <= 1'b1;
    jump(15'h0005);
    check("jump addr", 15'h0005, program_addr);
    check("bp stop", 0, seen);
    breakpoint_en <= 1'b0;
    k0 = n_init;
    go(3);
    wait_instr();
    check("restart", 1, seen);
    check("restart storage", k0, n_init);
    for (int i = 0; i < 7; i++) begin
      nis_storage_model_inst.mem[9] = {codes[i], 3'h7, 15'h000C, 24'h000000};
      k0 = n_init;
      jump(15'h0009);
      check("ind word", (i < 5) ? {codes[i], 3'h7, 15'h000C} : {codes[i], 3'h0, 15'h00AB},
            word);
      check("ind refs", (i < 5) ? 1 : 2, n_init - k0);
    end
    k0 = n_init;
    jump(15'h000A);
    check("chain word", {6'h0C, 3'h0, 15'h00AB}, word);
    check("chain refs", 3, n_init - k0);
    go(4);
    go(1);
    wait_instr();
    check("step stop", 0, seen);
    check("stop latch", 1, main_stop_latch);
    go(3);
    wait_instr();
    check("stop clear", 0, main_stop_latch);
    go(5);
    repeat (10) @(posedge clk);
    check("block", 1, second_request_block);
    check("saved pos", 0, saved_pair_position);
    check("ack off", 0, irq_ack_allowed);
    check("save addr", nis_pkg::IRQ_ADDR, wr_addr);
    check("save data", 15'h000A, stor_wdata);
    go(5);
    jump(nis_pkg::IRQ_ADDR);
    check("routine done", 1, routine_finished_flag);
    jump(15'h0005);
    check("block clear", 0, second_request_block);
    check("done clear", 0, routine_finished_flag);
    check("ack on", 1, irq_ack_allowed);
    check("resume half", W[23:0], word);
    sweep_mode <= 1'b1;
    k0 = n_init;
    go(0);
    wait_instr();
    check("sweep instr", 0, seen);
    check("sweep refetch", 1, (n_init - k0) >= 2);
    sweep_mode <= 1'b0;
    wait_instr();
    go(7);
    repeat (2) @(posedge clk);
    check("prog stop", 1, main_stop_latch);
    go(3);
    repeat (2) @(posedge clk);
    check("prog restart", 0, main_stop_latch);
    check("running", 1, running);
    go(6);
    repeat (4) @(posedge clk);
    check("fault halt", 0, running);
    print_verdict();
  end
endmodule : testbench
